// file: inc/sei_defines.vh
/*
 * Constants of the serial word memory command front end: field widths,
 * opcodes, the sub-codes of the control opcode and the timing figures.
 * Assumes it is included by bare name from design files under hw/.
 */
`ifndef SEI_DEFINES_VH
`define SEI_DEFINES_VH

// Opcode values of the two-bit field.
`define SEI_OP_CTRL 2'h0
`define SEI_OP_WRITE 2'h1
`define SEI_OP_READ 2'h2
`define SEI_OP_ERASE 2'h3

// Control sub-codes carried by the top two address bits.
`define SEI_SUB_WDIS 2'h0
`define SEI_SUB_WALL 2'h1
`define SEI_SUB_EALL 2'h2
`define SEI_SUB_WEN 2'h3

// Bit counts of the command after the start bit, and the number of words.
`define SEI_HDR_BITS 8
`define SEI_DATA_BITS 16
`define SEI_WORDS 16

// Erased word value.
`define SEI_ERASED 16'hffff

// Clock rate in kHz and the self-timed programming time in us.
`define SEI_CLK_KHZ 50000
`define SEI_PROG_TIME_US 15000
// Least deselect time in ns.
`define SEI_DESEL_MIN_NS 1000

`endif

// file: hw/sei_prog_timer.v
/*
 * Self-timed programming cycle counter of the serial word memory.
 * Assumes a single clock clk_in; start_in is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module sei_prog_timer #(
   parameter CYCLES = 750000,
   parameter CW = 20
) (
   // Clock and reset.
   input wire clk_in,
   input wire resetn_in,
   // Control.
   input wire start_in,
   // Status.
   output reg busy_out,
   output reg done_out
);

   // Remaining cycles of the current programming pass.
   reg [CW-1:0] count_reg;

   // Counts down once started; done pulses in the first cycle after busy falls.
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_reg <= {CW{1'b0}};
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_out) begin
            // Starting while busy is ignored so a pass is never cut short.
            count_reg <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            busy_out <= 1'b1;
         end else if (busy_out) begin
            if (count_reg == {CW{1'b0}}) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end else begin
               count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // sei_prog_timer

`default_nettype wire

// file: hw/sei_core.v
/*
 * Command front end of a 16 by 16-bit serial word memory. It samples the
 * select, serial clock and serial input pins on the system clock, decodes
 * the command bit stream and runs the self-timed programming pass.
 * Assumes the pins are asynchronous to clk_in and the serial clock is much
 * slower than clk_in, so each of its edges is seen as a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sei_defines.vh"

module sei_core #(
   parameter PROG_CYCLES = (`SEI_PROG_TIME_US * (`SEI_CLK_KHZ / 1000)),
   parameter DESEL_CYCLES =
      (`SEI_DESEL_MIN_NS * (`SEI_CLK_KHZ / 1000) + 999) / 1000
) (
   // Clock and reset.
   input wire clk_in,
   input wire resetn_in,
   // Serial link pins.
   input wire chip_select_in,
   input wire serial_clock_in,
   input wire serial_input_in,
   // Serial output pin as data and enable.
   output reg serial_output_out,
   output reg serial_output_oe_out
);

   // Sequencer states, one-hot. IDLE waits for the start bit and shows
   // status, HDR takes opcode and address, DATA takes the write word,
   // READ shifts the addressed word out and DONE waits for select to
   // fall. Keeping DONE separate is what lets a stray clock edge after
   // the last bit cancel a program start.
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_HDR = 5'h02;
   localparam [4:0] ST_DATA = 5'h04;
   localparam [4:0] ST_READ = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;

   // Two-stage synchronisers; stage one feeds only stage two.
   // The third register of select and clock only serves edge finding.
   reg cs_s1_reg, cs_s2_reg, cs_d_reg;
   reg sk_s1_reg, sk_s2_reg, sk_d_reg;
   reg di_s1_reg, di_s2_reg;

   // Memory array in flip-flops.
   // Reset fills it with the erased value, as after an erase all.
   reg [15:0] mem_reg [0:`SEI_WORDS-1];

   reg [4:0] state_reg; // Sequencer state.
   reg [7:0] hdr_reg; // Opcode and address shift register.
   reg [15:0] data_reg; // Write data or read shift register.
   reg [4:0] cnt_reg; // Bits taken in the current field.
   reg wen_reg; // Write enable latch.
   reg pend_reg; // An accepted program command waits for deselect.
   reg [15:0] pdata_reg; // Data of the pending pass.
   reg [3:0] paddr_reg; // Word of the pending pass.
   reg pall_reg; // Pending pass covers every word.
   reg status_reg; // Status display is active until a start bit or a long deselect, either with no pass running.
   reg [15:0] desel_cnt_reg; // Cycles spent deselected.
   reg start_pulse_reg; // Starts the programming pass.

   // Pin edges are seen two to three clk_in cycles late because of the
   // synchronisers; the serial clock must stay far slower than clk_in
   // or an edge could be missed between two samples.
   wire busy;
   wire done;
   wire sk_rise = sk_s2_reg && !sk_d_reg;
   wire cs_fall = cs_d_reg && !cs_s2_reg;
   wire [1:0] op = hdr_reg[7:6];
   wire [1:0] sub = hdr_reg[5:4];
   wire [3:0] waddr = hdr_reg[3:0];
   wire desel_ok = (desel_cnt_reg >= DESEL_CYCLES[15:0]);

   // Self-timed pass counter. It holds its own busy flag so that select
   // activity during a pass can never shorten or restart it.
   sei_prog_timer #(
      .CYCLES(PROG_CYCLES),
      .CW(24)
   ) u_timer (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .start_in(start_pulse_reg),
      .busy_out(busy),
      .done_out(done)
   );

   // Pin synchronisers and edge delay stages.
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cs_s1_reg <= 1'b0;
         cs_s2_reg <= 1'b0;
         cs_d_reg <= 1'b0;
         sk_s1_reg <= 1'b0;
         sk_s2_reg <= 1'b0;
         sk_d_reg <= 1'b0;
         di_s1_reg <= 1'b0;
         di_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg <= chip_select_in;
         cs_s2_reg <= cs_s1_reg;
         cs_d_reg <= cs_s2_reg;
         sk_s1_reg <= serial_clock_in;
         sk_s2_reg <= sk_s1_reg;
         sk_d_reg <= sk_s2_reg;
         di_s1_reg <= serial_input_in;
         di_s2_reg <= di_s1_reg;
      end
   end

   // Array update at the end of a pass; writes overwrite without erase.
   genvar gi;
   generate
      for (gi = 0; gi < `SEI_WORDS; gi = gi + 1) begin : g_word
         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               mem_reg[gi] <= `SEI_ERASED;
            end else if (done && (pall_reg || paddr_reg == gi)) begin
               mem_reg[gi] <= pdata_reg;
            end
         end
      end
   endgenerate

   // Time spent deselected, saturating; a short low does not reset.
   // Saturating keeps a long idle from wrapping round to a short count.
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         desel_cnt_reg <= 16'h0000;
      end else if (cs_s2_reg) begin
         desel_cnt_reg <= 16'h0000;
      end else if (!desel_ok) begin
         desel_cnt_reg <= desel_cnt_reg + 16'h0001;
      end
   end

   // Command sequencer, latch and pending-pass bookkeeping.
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= ST_IDLE;
         hdr_reg <= 8'h00;
         data_reg <= 16'h0000;
         cnt_reg <= 5'h00;
         wen_reg <= 1'b0;
         pend_reg <= 1'b0;
         pdata_reg <= 16'h0000;
         paddr_reg <= 4'h0;
         pall_reg <= 1'b0;
         status_reg <= 1'b0;
         start_pulse_reg <= 1'b0;
      end else begin
         start_pulse_reg <= 1'b0;
         if (cs_fall) begin
            // End of a cycle: latch commands and program starts act here.
            // A pending pass is dropped whatever happens, so it can
            // never start at a later, unrelated select fall.
            if (state_reg == ST_DONE && op == `SEI_OP_CTRL) begin
               if (sub == `SEI_SUB_WEN) begin
                  wen_reg <= 1'b1;
               end else if (sub == `SEI_SUB_WDIS) begin
                  wen_reg <= 1'b0;
               end
            end
            if (pend_reg && state_reg == ST_DONE && !busy) begin
               start_pulse_reg <= 1'b1;
            end
            pend_reg <= 1'b0;
            state_reg <= ST_IDLE;
         end else if (!cs_s2_reg) begin
            // Deselected: pins ignored; any low abandons the current command, and a
            // long enough low with no pass running also clears the status display.
            state_reg <= ST_IDLE;
            pend_reg <= 1'b0;
            if (desel_ok && !busy) begin
               status_reg <= 1'b0;
            end
         end else if (sk_rise) begin
            case (state_reg)
               ST_IDLE: begin
                  if (di_s2_reg) begin
                     state_reg <= ST_HDR;
                     cnt_reg <= 5'h00;
                     if (!busy) begin
                        status_reg <= 1'b0;
                     end
                  end
               end
               ST_HDR: begin
                  // Opcode then address, shifted in without gaps.
                  hdr_reg <= {hdr_reg[6:0], di_s2_reg};
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == `SEI_HDR_BITS - 1) begin
                     cnt_reg <= 5'h00;
                     if (hdr_reg[6:5] == `SEI_OP_READ) begin
                        // Load the addressed word; dummy zero goes first.
                        data_reg <= mem_reg[{hdr_reg[2:0], di_s2_reg}];
                        state_reg <= ST_READ;
                     end else if (hdr_reg[6:5] == `SEI_OP_WRITE ||
                        (hdr_reg[6:5] == `SEI_OP_CTRL &&
                         hdr_reg[4:3] == `SEI_SUB_WALL)) begin
                        state_reg <= ST_DATA;
                     end else begin
                        state_reg <= ST_DONE;
                        if (hdr_reg[6:5] == `SEI_OP_ERASE ||
                           (hdr_reg[6:5] == `SEI_OP_CTRL &&
                            hdr_reg[4:3] == `SEI_SUB_EALL)) begin
                           pend_reg <= wen_reg;
                           pdata_reg <= `SEI_ERASED;
                           paddr_reg <= {hdr_reg[2:0], di_s2_reg};
                           pall_reg <= (hdr_reg[6:5] == `SEI_OP_CTRL);
                        end
                     end
                  end
               end
               ST_DATA: begin
                  data_reg <= {data_reg[14:0], di_s2_reg};
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == `SEI_DATA_BITS - 1) begin
                     state_reg <= ST_DONE;
                     pend_reg <= wen_reg;
                     pdata_reg <= {data_reg[14:0], di_s2_reg};
                     paddr_reg <= waddr;
                     pall_reg <= (op == `SEI_OP_CTRL);
                  end
               end
               ST_READ: begin
                  // Each rising edge after the dummy moves out one bit.
                  // Zeros fill in behind, so extra edges read as zero.
                  if (cnt_reg != 5'h00) begin
                     data_reg <= {data_reg[14:0], 1'b0};
                  end
                  if (cnt_reg != `SEI_DATA_BITS) begin
                     cnt_reg <= cnt_reg + 5'h01;
                  end
               end
               ST_DONE: begin
                  // A clock edge after the last bit cancels the program
                  // start, since select must fall before it.
                  pend_reg <= 1'b0;
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
         // Placed last so a pass start wins over any clear in the same
         // cycle; a running pass must never hide its busy status.
         if (start_pulse_reg) begin
            status_reg <= 1'b1;
         end
      end
   end

   // Output pin: released when deselected, status while a pass is shown,
   // dummy zero then MSB-first data during a read.
   // Registered so the pin never glitches while the sequencer settles;
   // the cost is one more clk_in cycle of delay after each edge.
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         serial_output_out <= 1'b0;
         serial_output_oe_out <= 1'b0;
      end else if (!cs_s2_reg) begin
         serial_output_out <= 1'b0;
         serial_output_oe_out <= 1'b0;
      end else if (status_reg && state_reg == ST_IDLE) begin
         serial_output_out <= !busy;
         serial_output_oe_out <= 1'b1;
      end else if (state_reg == ST_READ) begin
         serial_output_out <= (cnt_reg == 5'h00) ? 1'b0 : data_reg[15];
         serial_output_oe_out <= 1'b1;
      end else begin
         serial_output_out <= 1'b0;
         serial_output_oe_out <= 1'b0;
      end
   end

endmodule // sei_core

`default_nettype wire

// file: verif/sei_core_props.sv
/* Pin checker of the serial memory front end.
   Assumes a bind to sei_core and a slow serial clock. */
`timescale 1ns/1ps
`default_nettype none
module sei_core_props #(
   parameter PROG_CYCLES = 200,
   parameter DESEL_CYCLES = 50
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic resetn_in,
   // Pins.
   input wire logic chip_select_in,
   input wire logic serial_clock_in,
   input wire logic serial_input_in,
   input wire logic serial_output_out,
   input wire logic serial_output_oe_out
);
   logic sk_reg; // Serial clock one cycle back.
   logic cs_reg; // Select one cycle back.
   logic [3:0] quiet_reg; // Cycles since the last pin event.
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // The output may only fall, or its drive change, on a clock rise or a select change.
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sk_reg <= 1'b0;
         cs_reg <= 1'b0;
         quiet_reg <= 4'hf;
      end else begin
         sk_reg <= serial_clock_in;
         cs_reg <= chip_select_in;
         if ((serial_clock_in && !sk_reg) || chip_select_in != cs_reg) begin
            quiet_reg <= 4'h0;
         end else if (quiet_reg != 4'hf) begin
            quiet_reg <= quiet_reg + 4'h1;
         end
      end
   end
   // Select held low long enough for the synchronisers.
   sequence s_desel;
      !chip_select_in [*6];
   endsequence
   // Driving with no pin activity for a while.
   sequence s_idle;
      serial_output_oe_out && quiet_reg > 4'h8;
   endsequence
   chk_oe_off_desel: assert property (
      s_desel |-> !serial_output_oe_out) else $error("drive unselected");
   chk_fall_on_edge: assert property (
      $fell(serial_output_out) && serial_output_oe_out &&
      $past(serial_output_oe_out) |-> quiet_reg < 4'h8)
      else $error("output fell without a clock rise");
   chk_oe_rise_cause: assert property (
      $rose(serial_output_oe_out) |-> quiet_reg < 4'h8)
      else $error("drive began without a pin event");
   chk_oe_fall_cause: assert property (
      $fell(serial_output_oe_out) |-> quiet_reg < 4'h8)
      else $error("drive ended without a pin event");
   chk_ready_holds: assert property (
      s_idle and serial_output_out |=> serial_output_out)
      else $error("ready dropped with no pin event");
   chk_oe_idle_stable: assert property (
      s_idle |=> serial_output_oe_out) else $error("drive dropped idle");
   chk_reset_quiet: assert property (
      $rose(resetn_in) |-> !serial_output_oe_out)
      else $error("driving at reset release");
   chk_oe_needs_cs: assert property (
      $rose(serial_output_oe_out) |-> $past(chip_select_in, 2))
      else $error("drive began while unselected");
endmodule // sei_core_props
bind sei_core sei_core_props #(.PROG_CYCLES(PROG_CYCLES),
   .DESEL_CYCLES(DESEL_CYCLES)) sei_core_props_inst (.clk_in(clk_in),
   .resetn_in(resetn_in), .chip_select_in(chip_select_in),
   .serial_clock_in(serial_clock_in), .serial_input_in(serial_input_in),
   .serial_output_out(serial_output_out),
   .serial_output_oe_out(serial_output_oe_out));
`default_nettype wire

// file: verif/sei_master.sv
/* Bus master model: select, serial clock and serial input.
   Assumes a 20 ns clk_in; one serial bit takes 8 clocks. */
`timescale 1ns/1ps
`default_nettype none
module sei_master (
   // Clock.
   input wire logic clk_in,
   // Pins to the device.
   output logic cs_out,
   output logic sk_out,
   output logic di_out,
   // Device output and its samples.
   input wire logic do_in,
   output logic stb_out,
   output logic val_out
);
   // Deselected, serial clock standing low.
   initial begin
      cs_out = 1'b0;
      sk_out = 1'b0;
      di_out = 1'b0;
      stb_out = 1'b0;
      val_out = 1'b0;
   end
   // Every change lands on a falling clk_in edge.
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Moves the three link pins together, once in a time step.
   task automatic pins(input logic cs, input logic sk, input logic di);
      cs_out = cs;
      sk_out = sk;
      di_out = di;
   endtask
   // Sends n bits MSB first, data set while the clock is low.
   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         pins(cs_out, 1'b0, v[i]);
         tick(4);
         pins(cs_out, 1'b1, di_out);
         tick(4);
      end
   endtask
   // Takes one sample of the output pin.
   task automatic look();
      val_out = do_in;
      stb_out = 1'b1;
      tick(1);
      stb_out = 1'b0;
   endtask
   // Samples n bits, each just before the next clock rise.
   task automatic rd(input int n);
      repeat (n) begin
         pins(cs_out, 1'b0, ~di_out); // Unused input keeps moving.
         tick(4);
         look();
         pins(cs_out, 1'b1, di_out);
         tick(3);
      end
   endtask
   // Selects; a start bit must come first.
   task automatic sel();
      pins(1'b1, sk_out, di_out);
      tick(4);
   endtask
   // Selects and looks at the status without any clock.
   task automatic stat();
      sel();
      tick(4);
      look();
   endtask
   // Deselects with the clock low, so no pass is cancelled; n of 50 or
   // more keeps the least deselect time before the next select.
   task automatic desel(input int n);
      pins(1'b0, 1'b0, ~di_out);
      tick(n);
   endtask
endmodule // sei_master
`default_nettype wire

// file: verif/tb_sei_core.sv
/* Testbench of the serial memory front end: the driver queues the
   expected pin samples and a monitor compares them.
   Assumes a 50 MHz clock and a 160 ns serial bit. */
`timescale 1ns/1ps
`default_nettype none
module tb_sei_core;
   localparam int PROG = 200; // Short pass keeps the run brief.
   logic clk_in, resetn_in;
   wire logic cs, sk, di, dout, doe, do_w, stb, val;
   logic [31:0] seed; // Xorshift state.
   logic exp_q[$]; // Expected samples, oldest first.
   int n_mismatch, tests_run;
   assign do_w = doe ? dout : 1'bz; // Pin level as the master sees it.
   sei_core #(.PROG_CYCLES(PROG)) sei_core_inst (.clk_in(clk_in),
      .resetn_in(resetn_in), .chip_select_in(cs), .serial_clock_in(sk),
      .serial_input_in(di), .serial_output_out(dout),
      .serial_output_oe_out(doe));
   sei_master sei_master_inst (.clk_in(clk_in), .cs_out(cs),
      .sk_out(sk), .di_out(di), .do_in(do_w), .stb_out(stb),
      .val_out(val));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic seen, input logic e);
      tests_run++;
      if (seen !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %b, expected %b", $time, seen, e);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0 && exp_q.size() == 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // A sample with no note waiting is a failure too.
   always @(posedge clk_in) begin
      if (stb === 1'b1) begin
         if (exp_q.size() == 0) check(1'bx, 1'b0);
         else check(val, exp_q.pop_front());
      end
   end
   // Holds reset for n cycles, then lets the synchronisers settle.
   task automatic pulse_reset(input int n);
      resetn_in = 1'b0;
      repeat (n) @(negedge clk_in);
      resetn_in = 1'b1;
      sei_master_inst.tick(4);
   endtask
   // Zeros, start bit, opcode and address.
   task automatic head(input logic [1:0] op, input logic [5:0] a,
         input int z);
      sei_master_inst.sel();
      if (z > 0) sei_master_inst.send(32'h0, z);
      sei_master_inst.send({23'h0, 1'b1, op, a}, 9);
   endtask
   task automatic rd_word(input logic [5:0] a, input logic [15:0] e,
         input int z);
      head(2'h2, a, z);
      exp_q.push_back(1'b0);
      for (int i = 15; i >= 0; i--) exp_q.push_back(e[i]);
      sei_master_inst.rd(17);
      sei_master_inst.desel(60);
   endtask
   // Runs a command; pass says whether a busy phase must follow.
   task automatic prog(input logic [1:0] op, input logic [5:0] a,
         input logic [15:0] d, input logic pass);
      head(op, a, 0);
      if (op == 2'h1 || (op == 2'h0 && a[5:4] == 2'h1)) begin
         sei_master_inst.send({16'h0, d}, 16);
      end
      sei_master_inst.desel(60);
      exp_q.push_back(pass ? 1'b0 : 1'bz);
      sei_master_inst.stat();
      if (pass) begin
         sei_master_inst.desel(60);
         exp_q.push_back(1'b0);
         sei_master_inst.stat();
         sei_master_inst.tick(PROG);
         exp_q.push_back(1'b1);
         sei_master_inst.look();
         sei_master_inst.send(32'h1, 1);
         sei_master_inst.tick(4);
         exp_q.push_back(1'bz);
         sei_master_inst.look();
      end
      sei_master_inst.desel(60);
   endtask
   initial begin
      logic [15:0] d;
      logic [3:0] a;
      n_mismatch = 0;
      tests_run = 0;
      seed = 32'hd63c;
      pulse_reset(6);
      rd_word(6'h00, 16'hffff, 0);
      prog(2'h1, 6'h05, 16'h1234, 1'b0);
      rd_word(6'h05, 16'hffff, 3);
      $display("test locked done");
      prog(2'h0, 6'h30, 16'h0, 1'b0);
      repeat (4) begin
         seed = xs(seed);
         a = seed[3:0];
         d = seed[19:4];
         prog(2'h1, {2'h0, a}, d, 1'b1);
         rd_word({2'h3, a}, d, 0);
         prog(2'h1, {2'h0, a}, ~d, 1'b1);
         rd_word({2'h0, a}, ~d, 0);
         prog(2'h3, {2'h0, a}, 16'h0, 1'b1);
         rd_word({2'h1, a}, 16'hffff, 0);
      end
      $display("test word done");
      prog(2'h0, 6'h10, d, 1'b1);
      rd_word(6'h0f, d, 0);
      prog(2'h0, 6'h20, 16'h0, 1'b1);
      rd_word(6'h02, 16'hffff, 0);
      pulse_reset(3);
      prog(2'h1, 6'h07, d, 1'b0);
      rd_word(6'h07, 16'hffff, 0);
      prog(2'h0, 6'h30, 16'h0, 1'b0);
      prog(2'h0, 6'h00, 16'h0, 1'b0);
      prog(2'h1, 6'h02, d, 1'b0);
      rd_word(6'h02, 16'hffff, 0);
      $display("test all done");
      complete_run();
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (40000) @(posedge clk_in);
      n_mismatch++;
      complete_run();
   end
endmodule // tb_sei_core
`default_nettype wire
